// [rtl/expander_pkg.sv]
// Constants, tables and carrier types of the interrupt expander and reset logic
package expander_pkg;
   localparam int NUM_SRC = 23;
   localparam int NUM_BIT = 31;
   localparam int NUM_LINE = 6;
   localparam logic [1:0] PRIO_ANY = 2'h0;
   localparam logic [1:0] PRIO_HI = 2'h1;
   localparam logic [1:0] PRIO_LO = 2'h2;
   // Request bit n: reg0.n for n < 16, reg1.(n-16) above
   localparam logic [4:0] BIT_SRC [NUM_BIT] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
      5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11,
      5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h01, 5'h02, 5'h03};
   localparam logic [1:0] BIT_PRIO [NUM_BIT] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1,
      2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
      2'h0, 2'h0, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2};
   localparam logic [15:0] BIT_VEC [NUM_BIT] = '{16'h0020, 16'h0004, 16'h0001, 16'h0011,
      16'h0005, 16'h0006, 16'h0007, 16'h0040, 16'h0041, 16'h0021, 16'h0022, 16'h0023,
      16'h0027, 16'h0028, 16'h0029, 16'h002A, 16'h002B, 16'h002C, 16'h002D, 16'h002E,
      16'h0033, 16'h0034, 16'h0035, 16'h0005, 16'h0006, 16'h0007, 16'h0040, 16'h0041,
      16'h0004, 16'h0001, 16'h0011};
   localparam logic [30:0] LINE_MASK [NUM_LINE] = '{31'h000001FF, 31'h0000FE00,
      31'h000F0000, 31'h00700000, 31'h1F800000, 31'h60000000};
   localparam logic [15:0] LINE_VEC_ADDR [NUM_LINE] = '{16'h0002, 16'h0004, 16'h0006,
      16'h0008, 16'h000A, 16'h000C};
   localparam logic [15:0] RESET_VECTOR = 16'h0000;
   localparam logic [15:0] PHANTOM_VECTOR = 16'h0000;
   localparam logic [1:0] INT_PULSE_CYCLES = 2'h2;
   localparam logic [3:0] RST_PULSE_CYCLES = 4'h8;
   localparam int WD_TIMEOUT_DEFAULT = 65536;
   localparam logic [7:0] WD_KEY_ARM = 8'h55;
   localparam logic [7:0] WD_KEY_SERVICE = 8'hAA;
   localparam int WD_CHECK_POS = 3;
   localparam logic [2:0] WD_CHECK_VAL = 3'h5;
   localparam logic [7:0] REQ0_OFS = 8'h00;
   localparam logic [7:0] REQ1_OFS = 8'h04;
   localparam logic [7:0] FLAG_OFS = 8'h08;
   localparam logic [7:0] ENABLE_OFS = 8'h0C;
   localparam logic [7:0] VECTOR_OFS = 8'h10;
   localparam logic [7:0] WD_KEY_OFS = 8'h14;
   localparam logic [7:0] WD_CTRL_OFS = 8'h18;
   localparam logic [22:0] ENABLE_RST = 23'h000000;
   localparam logic [2:0] WD_CTRL_RST = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef struct packed {
      logic [7:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [7:0] araddr;
      logic arvalid;
      logic rready;
   } axi_req_s;
   typedef struct packed {
      logic awready;
      logic wready;
      logic [1:0] bresp;
      logic bvalid;
      logic arready;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rvalid;
   } axi_rsp_s;
   typedef struct packed {
      logic [22:0] event_pulse;
      logic [22:0] prio_hi;
   } event_in_s;
   typedef struct packed {
      logic ack;
      logic [15:0] ack_addr;
   } cpu_ack_s;
endpackage : expander_pkg

// [rtl/interrupt_expander.sv]
// Peripheral interrupt expander with watchdog and reset pin logic
`timescale 1ns/10ps
// Contract
// - Watchdog overflow or bad key or bad control write raises a watchdog reset.
// - Watchdog counts from power-on without software starting it.
// - Watchdog reset drives the reset pin low at least eight cycles.
// - Reset halts the CPU and restores control bits, RAM untouched.
// - Many event requests are arbitrated onto six maskable CPU lines.
// - Event request equals flag AND enable, dropping when flag clears.
// - Priority bit routes selectable events to high or low group.
// - Request stays until cleared by acknowledge or software.
// - Requests sharing a CPU line are ORed into that line.
// - Line request is an active-low pulse of exactly two cycles.
// - Acknowledge clears only the highest-priority pending request of its line.
// - Requests still active after acknowledge cause another pulse.
// - Mapping and priority are fixed here; reset vector 0000h unmaskable.
// - Power-protect event is bit 0.0, line 1, vector 0020h.
// - Line 1 high-priority events occupy bits 0.1 to 0.8.
// - Line 2 carries compare and timer-1 events, bits 0.9 to 0.15.
// - Line 3 carries timer-2 events, bits 1.0 to 1.3.
// - Line 4 carries capture events 1 to 3, bits 1.4 to 1.6.
// - Line 5 carries low-priority serial, CAN and converter events, bits 1.7-1.12.
// - Line 6 carries low-priority external inputs, bits 1.13 and 1.14.
// - Acknowledge loads the event vector into the readable vector register.
// - Acknowledge with nothing pending loads fault vector 0000h.
module interrupt_expander
   import expander_pkg::*;
#(
   parameter int unsigned WD_TIMEOUT_CYCLES = WD_TIMEOUT_DEFAULT
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire axi_req_s axi_in,
   output axi_rsp_s axi_out,
   // Peripheral events
   input wire event_in_s evt,
   // CPU side
   input wire cpu_ack_s cpu,
   output logic [5:0] cpu_int_n,
   output logic [15:0] event_vector,
   output logic cpu_reset_n,
   // Reset pin, open drain
   input wire logic reset_pin_n_in,
   output logic reset_pin_n_out,
   output logic reset_pin_n_oe
);
   logic pin_s1_r;
   logic pin_s2_r;
   logic [3:0] rst_cnt_r;
   logic rst_oe_r;
   logic sys_rst;
   logic [31:0] wd_cnt_r;
   logic wd_armed_r;
   logic [2:0] wd_ctrl_r;
   logic wd_fire_r;
   logic wd_fire_nxt;
   logic key_bad;
   logic key_service;
   logic ctrl_bad;
   logic [22:0] flag_r;
   logic [22:0] flag_nxt;
   logic [22:0] enable_r;
   logic [22:0] sw_clr;
   logic [22:0] ack_clr;
   logic [30:0] req;
   logic [5:0] line_req;
   logic [5:0] line_trig;
   logic [5:0] prev_req_r;
   logic [5:0] ack_d_r;
   logic [1:0] pulse_cnt_r [NUM_LINE];
   logic [5:0] int_n_r;
   logic [15:0] vector_r;
   logic cpu_reset_n_r;
   logic ack_line_ok;
   logic [2:0] ack_l;
   logic ack_hit;
   logic [4:0] ack_bit;
   logic [4:0] ack_src;
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic arready_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic do_wr;
   logic [31:0] wmask;
   logic [31:0] wbits;

   // Pin synchroniser and local reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_s1_r <= 1'b1;
         pin_s2_r <= 1'b1;
      end
      else
      begin
         pin_s1_r <= reset_pin_n_in;
         pin_s2_r <= pin_s1_r;
      end
   end

   assign sys_rst = !aresetn || !pin_s2_r || (rst_cnt_r != 4'h0);

   // Reset pin drive; only the bus reset clears it so the pin cannot cut its own pulse
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rst_cnt_r <= 4'h0;
         rst_oe_r <= 1'b0;
      end
      else if (wd_fire_r)
      begin
         rst_cnt_r <= RST_PULSE_CYCLES;
         rst_oe_r <= 1'b1;
      end
      else
      begin
         rst_cnt_r <= (rst_cnt_r != 4'h0) ? rst_cnt_r - 4'h1 : 4'h0;
         rst_oe_r <= (rst_cnt_r > 4'h1);
      end
   end

   always_ff @(posedge aclk)
   begin
      if (sys_rst)
         cpu_reset_n_r <= 1'b0;
      else
         cpu_reset_n_r <= 1'b1;
   end

   // Watchdog
   assign key_bad = do_wr && (awaddr_r == WD_KEY_OFS) && wstrb_r[0]
      && (wdata_r[7:0] != WD_KEY_ARM) && (wdata_r[7:0] != WD_KEY_SERVICE);
   assign key_service = do_wr && (awaddr_r == WD_KEY_OFS) && wstrb_r[0]
      && (wdata_r[7:0] == WD_KEY_SERVICE) && wd_armed_r;
   assign ctrl_bad = do_wr && (awaddr_r == WD_CTRL_OFS) && wstrb_r[0]
      && (wdata_r[WD_CHECK_POS +: 3] != WD_CHECK_VAL);
   assign wd_fire_nxt = !sys_rst
      && ((wd_cnt_r == 32'(WD_TIMEOUT_CYCLES - 1)) || key_bad || ctrl_bad);

   always_ff @(posedge aclk)
   begin
      if (sys_rst)
      begin
         wd_cnt_r <= 32'h0;
         wd_armed_r <= 1'b0;
         wd_ctrl_r <= WD_CTRL_RST;
         wd_fire_r <= 1'b0;
      end
      else
      begin
         wd_fire_r <= wd_fire_nxt;
         wd_cnt_r <= key_service ? 32'h0 : wd_cnt_r + 32'h1;
         if (do_wr && (awaddr_r == WD_KEY_OFS) && wstrb_r[0])
            wd_armed_r <= (wdata_r[7:0] == WD_KEY_ARM);
         if (do_wr && (awaddr_r == WD_CTRL_OFS) && wstrb_r[0] && !ctrl_bad)
            wd_ctrl_r <= wdata_r[2:0];
      end
   end

   // Request bits from flag, enable and priority routing
   generate
      for (genvar b = 0; b < NUM_BIT; b++)
      begin : g_req
         assign req[b] = flag_r[BIT_SRC[b]] && enable_r[BIT_SRC[b]]
            && ((BIT_PRIO[b] == PRIO_ANY)
            || ((BIT_PRIO[b] == PRIO_HI) == evt.prio_hi[BIT_SRC[b]]));
      end
      for (genvar l = 0; l < NUM_LINE; l++)
      begin : g_line
         assign line_req[l] = |(req & LINE_MASK[l]);
         assign line_trig[l] = line_req[l] && (!prev_req_r[l] || ack_d_r[l]);
      end
   endgenerate

   // Acknowledge: lowest bit of the line wins
   always_comb
   begin
      ack_line_ok = 1'b0;
      ack_l = 3'h0;
      ack_hit = 1'b0;
      ack_bit = 5'h00;
      for (int l = 0; l < NUM_LINE; l++)
      begin
         if (cpu.ack_addr == LINE_VEC_ADDR[l])
         begin
            ack_line_ok = 1'b1;
            ack_l = 3'(l);
         end
      end
      for (int b = NUM_BIT - 1; b >= 0; b--)
      begin
         if (cpu.ack && ack_line_ok && LINE_MASK[ack_l][b] && req[b])
         begin
            ack_hit = 1'b1;
            ack_bit = 5'(b);
         end
      end
   end

   assign ack_src = BIT_SRC[ack_bit];
   assign ack_clr = ack_hit ? (23'h000001 << ack_src) : 23'h000000;
   assign flag_nxt = (flag_r & ~sw_clr & ~ack_clr) | evt.event_pulse;

   always_ff @(posedge aclk)
   begin
      if (sys_rst)
         flag_r <= 23'h000000;
      else
         flag_r <= flag_nxt;
   end

   always_ff @(posedge aclk)
   begin
      if (sys_rst)
         vector_r <= RESET_VECTOR;
      else if (ack_hit)
         vector_r <= BIT_VEC[ack_bit];
      else if (cpu.ack)
         vector_r <= PHANTOM_VECTOR;
   end

   // Line pulse generators
   always_ff @(posedge aclk)
   begin
      if (sys_rst)
      begin
         prev_req_r <= 6'h00;
         ack_d_r <= 6'h00;
         int_n_r <= 6'h3F;
         for (int l = 0; l < NUM_LINE; l++)
            pulse_cnt_r[l] <= 2'h0;
      end
      else
      begin
         prev_req_r <= line_req;
         for (int l = 0; l < NUM_LINE; l++)
         begin
            ack_d_r[l] <= cpu.ack && ack_line_ok && (ack_l == 3'(l));
            if (line_trig[l])
            begin
               pulse_cnt_r[l] <= INT_PULSE_CYCLES;
               int_n_r[l] <= 1'b0;
            end
            else
            begin
               pulse_cnt_r[l] <= (pulse_cnt_r[l] != 2'h0) ? pulse_cnt_r[l] - 2'h1 : 2'h0;
               int_n_r[l] <= (pulse_cnt_r[l] <= 2'h1);
            end
         end
      end
   end

   // Bus slave: write channel
   assign do_wr = !awready_r && !wready_r && !bvalid_r;
   generate
      for (genvar i = 0; i < 4; i++)
      begin : g_mask
         assign wmask[8 * i +: 8] = {8{wstrb_r[i]}};
      end
   endgenerate
   assign wbits = wdata_r & wmask;
   assign sw_clr = (do_wr && (awaddr_r == FLAG_OFS)) ? wbits[22:0] : 23'h000000;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
      end
      else
      begin
         if (awready_r && axi_in.awvalid)
         begin
            awready_r <= 1'b0;
            awaddr_r <= axi_in.awaddr;
         end
         if (wready_r && axi_in.wvalid)
         begin
            wready_r <= 1'b0;
            wdata_r <= axi_in.wdata;
            wstrb_r <= axi_in.wstrb;
         end
         if (do_wr)
         begin
            bvalid_r <= 1'b1;
            if (awaddr_r == REQ0_OFS || awaddr_r == REQ1_OFS || awaddr_r == FLAG_OFS
               || awaddr_r == ENABLE_OFS || awaddr_r == VECTOR_OFS
               || awaddr_r == WD_KEY_OFS || awaddr_r == WD_CTRL_OFS)
               bresp_r <= RESP_OKAY;
            else
               bresp_r <= RESP_SLVERR;
         end
         else if (bvalid_r && axi_in.bready)
         begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (sys_rst)
         enable_r <= ENABLE_RST;
      else if (do_wr && (awaddr_r == ENABLE_OFS))
         enable_r <= (enable_r & ~wmask[22:0]) | wbits[22:0];
   end

   // Bus slave: read channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0;
         rresp_r <= RESP_OKAY;
      end
      else if (arready_r && axi_in.arvalid)
      begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rresp_r <= RESP_OKAY;
         if (axi_in.araddr == REQ0_OFS)
            rdata_r <= {16'h0, req[15:0]};
         else if (axi_in.araddr == REQ1_OFS)
            rdata_r <= {17'h0, req[30:16]};
         else if (axi_in.araddr == FLAG_OFS)
            rdata_r <= {9'h0, flag_r};
         else if (axi_in.araddr == ENABLE_OFS)
            rdata_r <= {9'h0, enable_r};
         else if (axi_in.araddr == VECTOR_OFS)
            rdata_r <= {16'h0, vector_r};
         else if (axi_in.araddr == WD_KEY_OFS)
            rdata_r <= 32'h0;
         else if (axi_in.araddr == WD_CTRL_OFS)
            rdata_r <= {29'h0, wd_ctrl_r};
         else
         begin
            rdata_r <= 32'h0;
            rresp_r <= RESP_SLVERR;
         end
      end
      else if (rvalid_r && axi_in.rready)
      begin
         rvalid_r <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   assign axi_out = '{awready: awready_r, wready: wready_r, bresp: bresp_r, bvalid: bvalid_r,
      arready: arready_r, rdata: rdata_r, rresp: rresp_r, rvalid: rvalid_r};
   assign cpu_int_n = int_n_r;
   assign event_vector = vector_r;
   assign cpu_reset_n = cpu_reset_n_r;
   assign reset_pin_n_out = 1'b0;
   assign reset_pin_n_oe = rst_oe_r;

   // Checks
   int_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(int_n_r[0]) |-> !int_n_r[0] ##1 (!int_n_r[0] || sys_rst))
      else $error("line pulse shorter than two cycles");
   int_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !int_n_r[1] && pulse_cnt_r[1] == 2'h1 && !line_trig[1] |=> int_n_r[1])
      else $error("line pulse longer than two cycles");
   trig_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
      line_trig[0] && !sys_rst |=> !int_n_r[0] ##1 !int_n_r[0] || sys_rst)
      else $error("pending request gave no pulse");
   req_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
      sw_clr[9] && !evt.event_pulse[9] |=> !req[9])
      else $error("request stayed after flag clear");
   ack_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ack_hit && !evt.event_pulse[ack_src] |=> (flag_r & (23'h000001 << $past(ack_src))) == 0)
      else $error("acknowledge left flag set");
   vec_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ack_hit && !sys_rst |=> vector_r == $past(BIT_VEC[ack_bit]))
      else $error("vector not loaded");
   phantom_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cpu.ack && !ack_hit && !sys_rst |=> vector_r == PHANTOM_VECTOR)
      else $error("phantom vector missing");
   rst_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(rst_oe_r) |-> rst_oe_r[*8])
      else $error("reset pin drive too short");
   wd_fire_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wd_fire_nxt |=> ##2 rst_oe_r && !cpu_reset_n_r)
      else $error("watchdog fault not driven out");
endmodule : interrupt_expander

// [verification/cpu_periph_model.sv]
// CPU core and peripheral event sources facing the interrupt expander
`timescale 1ns/10ps
module cpu_periph_model
   import expander_pkg::*;
(
   // Clock
   input wire logic aclk,
   // Towards the expander
   output event_in_s evt,
   output cpu_ack_s cpu
);
   initial
   begin
      evt = '0;
      cpu = '0;
   end

   // One-cycle event pulses; priority bits stay as levels afterwards
   task automatic fire(input logic [22:0] srcs, input logic [22:0] hi);
      @(posedge aclk);
      evt.prio_hi <= hi;
      evt.event_pulse <= srcs;
      @(posedge aclk);
      evt.event_pulse <= '0;
   endtask : fire

   // Acknowledge puts the vector address of the line on the address bus
   task automatic ack_line(input int l);
      @(posedge aclk);
      cpu.ack <= 1'b1;
      cpu.ack_addr <= 16'h0002 + 16'(2 * l);
      @(posedge aclk);
      cpu.ack <= 1'b0;
      cpu.ack_addr <= ~cpu.ack_addr;
   endtask : ack_line
endmodule : cpu_periph_model

// [verification/peripheral_interrupt_expander_reset_tb.sv]
// Self-checking bench of the interrupt expander and reset logic
`timescale 1ns/10ps
module peripheral_interrupt_expander_reset_tb;
   import expander_pkg::*;
   localparam int WD = 400;
   localparam int LO_SRC [8] = '{4, 5, 6, 7, 8, 1, 2, 3};
   localparam logic [15:0] VEC [31] = '{16'h0020, 16'h0004, 16'h0001, 16'h0011, 16'h0005,
      16'h0006, 16'h0007, 16'h0040, 16'h0041, 16'h0021, 16'h0022, 16'h0023, 16'h0027,
      16'h0028, 16'h0029, 16'h002A, 16'h002B, 16'h002C, 16'h002D, 16'h002E, 16'h0033,
      16'h0034, 16'h0035, 16'h0005, 16'h0006, 16'h0007, 16'h0040, 16'h0041, 16'h0004,
      16'h0001, 16'h0011};
   logic aclk, aresetn, ext_rst_n, cpu_reset_n, pin_out, reset_pin_n_oe;
   axi_req_s axi_in;
   axi_rsp_s axi_out;
   event_in_s evt;
   cpu_ack_s cpu;
   logic [5:0] cpu_int_n;
   logic [15:0] event_vector;
   wire logic pin_level;
   int bad_count = 0;
   int num_checks = 0;

   // Open-drain pin with pull-up
   assign pin_level = (reset_pin_n_oe && !pin_out) ? 1'b0 : ext_rst_n;

   interrupt_expander #(.WD_TIMEOUT_CYCLES(WD)) interrupt_expander_inst (.aclk(aclk),
      .aresetn(aresetn), .axi_in(axi_in), .axi_out(axi_out), .evt(evt), .cpu(cpu),
      .cpu_int_n(cpu_int_n), .event_vector(event_vector), .cpu_reset_n(cpu_reset_n),
      .reset_pin_n_in(pin_level), .reset_pin_n_out(pin_out),
      .reset_pin_n_oe(reset_pin_n_oe));
   cpu_periph_model cpu_periph_model_inst (.aclk(aclk), .evt(evt), .cpu(cpu));

   initial
   begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   task automatic finish_test;
      if (bad_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : finish_test

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   function automatic logic sig(input int w);
      if (w < 6)
         return cpu_int_n[w];
      if (w == 6)
         return reset_pin_n_oe;
      return cpu_reset_n;
   endfunction : sig

   // Counts edges until the watched output shows lvl; must means a limit is fatal
   task automatic wait_lvl(input int w, input logic lvl, input int lim, output int c,
      input bit must);
      c = 0;
      // Step off the edge so outputs launched by it are settled
      #1;
      while (sig(w) !== lvl && c < lim)
      begin
         @(posedge aclk);
         #1;
         c++;
      end
      if (must && sig(w) !== lvl)
      begin
         chk("wait limit", 32'h0, 32'h1);
         finish_test();
      end
   endtask : wait_lvl

   task automatic pulse(input int l);
      int c;
      wait_lvl(l, 1'b0, 10, c, 1'b1);
      wait_lvl(l, 1'b1, 10, c, 1'b1);
      chk("pulse width", 32'h2, 32'(c));
   endtask : pulse

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n = 0;
      @(posedge aclk);
      axi_in.awaddr <= a;
      axi_in.wdata <= d;
      axi_in.wstrb <= 4'hF;
      axi_in.awvalid <= 1'b1;
      axi_in.wvalid <= 1'b1;
      axi_in.bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (axi_out.awready === 1'b1)
            axi_in.awvalid <= 1'b0;
         if (axi_out.wready === 1'b1)
            axi_in.wvalid <= 1'b0;
      end
      while (axi_out.bvalid !== 1'b1 && n < 50);
      axi_in.bready <= 1'b0;
      if (n == 50)
         wait_lvl(0, 1'bz, 0, n, 1'b1);
      chk("bresp", 32'(er), 32'(axi_out.bresp));
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      int n = 0;
      @(posedge aclk);
      axi_in.araddr <= a;
      axi_in.arvalid <= 1'b1;
      axi_in.rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (axi_out.arready === 1'b1)
            axi_in.arvalid <= 1'b0;
      end
      while (axi_out.rvalid !== 1'b1 && n < 50);
      axi_in.rready <= 1'b0;
      d = axi_out.rdata;
      if (n == 50)
         wait_lvl(0, 1'bz, 0, n, 1'b1);
      chk("rresp", 32'(er), 32'(axi_out.rresp));
   endtask : axi_rd

   task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      axi_rd(a, d, RESP_OKAY);
      chk(n, e, d);
   endtask : rd_chk

   task automatic kick;
      axi_wr(WD_KEY_OFS, 32'(WD_KEY_ARM), RESP_OKAY);
      axi_wr(WD_KEY_OFS, 32'(WD_KEY_SERVICE), RESP_OKAY);
   endtask : kick

   task automatic ack_chk(input int l, input logic [15:0] e);
      cpu_periph_model_inst.ack_line(l);
      @(posedge aclk);
      #1;
      chk("vector", 32'(e), 32'(event_vector));
   endtask : ack_chk

   initial
   begin
      #2_000_000;
      chk("run time", 32'h0, 32'h1);
      finish_test();
   end

   initial
   begin
      int c;
      int s;
      int l;
      logic [31:0] d;
      aresetn = 1'b0;
      ext_rst_n = 1'b1;
      axi_in = '0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      wait_lvl(7, 1'b1, 6, c, 1'b1);
      chk("lines idle", 32'h3F, 32'(cpu_int_n));
      chk("vector reset", 32'h0, 32'(event_vector));
      rd_chk("enable reset", ENABLE_OFS, 32'h0);
      axi_rd(8'h1C, d, RESP_SLVERR);
      chk("unmapped read", 32'h0, d);
      axi_wr(8'h1C, 32'h1, RESP_SLVERR);
      axi_wr(ENABLE_OFS, 32'h007FFFFF, RESP_OKAY);
      // Every request bit: line, bit position, pulse and vector
      for (int b = 0; b < 31; b++)
      begin
         s = (b < 23) ? b : LO_SRC[b - 23];
         l = (b < 9) ? 0 : (b < 16) ? 1 : (b < 20) ? 2 : (b < 23) ? 3 : (b < 29) ? 4 : 5;
         kick();
         cpu_periph_model_inst.fire(23'(1) << s, (b >= 1 && b <= 8) ? 23'(1) << s : '0);
         pulse(l);
         if (b < 16)
            rd_chk("req0 bit", REQ0_OFS, 32'(1) << b);
         else
            rd_chk("req1 bit", REQ1_OFS, 32'(1) << (b - 16));
         ack_chk(l, VEC[b]);
         rd_chk("req cleared", (b < 16) ? REQ0_OFS : REQ1_OFS, 32'h0);
      end
      // Two captures on one line: priority order and re-issued pulse
      kick();
      cpu_periph_model_inst.fire(23'h500000, '0);
      pulse(3);
      ack_chk(3, 16'h0033);
      pulse(3);
      ack_chk(3, 16'h0035);
      wait_lvl(3, 1'b0, 6, c, 1'b0);
      chk("no pulse left", 32'd6, 32'(c));
      ack_chk(3, 16'h0000);
      // Flag gated by enable, cleared by software
      kick();
      axi_wr(ENABLE_OFS, 32'h007FFDFF, RESP_OKAY);
      cpu_periph_model_inst.fire(23'h000200, '0);
      wait_lvl(1, 1'b0, 6, c, 1'b0);
      chk("masked pulse", 32'd6, 32'(c));
      rd_chk("masked req", REQ0_OFS, 32'h0);
      axi_wr(ENABLE_OFS, 32'h007FFFFF, RESP_OKAY);
      pulse(1);
      rd_chk("enabled req", REQ0_OFS, 32'h200);
      axi_wr(FLAG_OFS, 32'h200, RESP_OKAY);
      rd_chk("flag cleared", REQ0_OFS, 32'h0);
      ack_chk(1, 16'h0000);
      // Watchdog: control write, bad key, overflow, bad control
      kick();
      axi_wr(WD_CTRL_OFS, 32'h2B, RESP_OKAY);
      axi_rd(WD_CTRL_OFS, d, RESP_OKAY);
      chk("wd ctrl bits", 32'h3, {29'h0, d[2:0]});
      chk("no wd reset", 32'h0, 32'(reset_pin_n_oe));
      axi_wr(WD_KEY_OFS, 32'h12, RESP_OKAY);
      wait_lvl(6, 1'b1, 10, c, 1'b1);
      wait_lvl(6, 1'b0, 20, c, 1'b1);
      chk("pin low length", 32'h1, 32'(c >= 8));
      chk("cpu held", 32'h0, 32'(cpu_reset_n));
      wait_lvl(7, 1'b1, 10, c, 1'b1);
      rd_chk("enable restored", ENABLE_OFS, 32'h0);
      wait_lvl(6, 1'b1, WD + 20, c, 1'b1);
      chk("overflow time", 32'h1, 32'(c >= WD - 10));
      wait_lvl(6, 1'b0, 20, c, 1'b1);
      wait_lvl(7, 1'b1, 10, c, 1'b1);
      axi_wr(WD_CTRL_OFS, 32'h0, RESP_OKAY);
      wait_lvl(6, 1'b1, 10, c, 1'b1);
      wait_lvl(6, 1'b0, 20, c, 1'b1);
      wait_lvl(7, 1'b1, 10, c, 1'b1);
      // External pin pulse of one cycle
      kick();
      axi_wr(ENABLE_OFS, 32'h1, RESP_OKAY);
      @(posedge aclk);
      ext_rst_n <= 1'b0;
      @(posedge aclk);
      ext_rst_n <= 1'b1;
      wait_lvl(7, 1'b0, 6, c, 1'b1);
      wait_lvl(7, 1'b1, 10, c, 1'b1);
      rd_chk("pin reset enable", ENABLE_OFS, 32'h0);
      finish_test();
   end
endmodule : peripheral_interrupt_expander_reset_tb
